// ===== verilog/rsr_pkg.sv
package rsr_pkg;

  // ****************************************************************
  // bus geometry
  // ****************************************************************
  localparam int          PADDR_W   = 10;
  localparam int          PDATA_W   = 32;
  localparam int          REG_W     = 8;
  localparam int          IRQ_W     = 3;
  localparam logic [23:0] PAD_ZERO  = 24'h000000;
  localparam logic [1:0]  WORD_LSB  = 2'h0;

  // ****************************************************************
  // register indices; byte address is four times the index
  // ****************************************************************
  localparam logic [7:0] IDX_SIGNAL_LEVEL   = 8'h26;
  localparam logic [7:0] IDX_CLEAR_THRESH   = 8'h27;
  localparam logic [7:0] IDX_ANT_ONE_LEVEL  = 8'h28;
  localparam logic [7:0] IDX_ANT_TWO_LEVEL  = 8'h29;
  localparam logic [7:0] IDX_FREQ_LIMIT     = 8'h2A;
  localparam logic [7:0] IDX_FREQ_CORR_HIGH = 8'h2B;
  localparam logic [7:0] IDX_ONOFF_HIGH     = 8'h2C;
  localparam logic [7:0] IDX_ONOFF_LOW      = 8'h2D;
  localparam logic [7:0] IDX_SLICER_RATES   = 8'h2E;
  localparam logic [7:0] IDX_IRQ_STATUS     = 8'h40;
  localparam logic [7:0] IDX_IRQ_MASK       = 8'h41;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] RST_LEVEL      = 8'h00;
  localparam logic [7:0] RST_THRESH     = 8'h1E;
  localparam logic [7:0] RST_FREQ_LIMIT = 8'h2A;
  localparam logic [9:0] RST_FREQ_CORR  = 10'h000;
  localparam logic [5:0] RST_ONOFF_HIGH = 6'h2C;
  localparam logic [7:0] RST_ONOFF_LOW  = 8'h00;
  localparam logic [7:0] RST_SLICER     = 8'h00;
  localparam logic [2:0] RST_IRQ        = 3'h0;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int BIT_FREEZE   = 5;
  localparam int BIT_PEAK_DET = 4;
  localparam int BIT_MOV_AVG  = 3;
  localparam int EVT_CLEAR    = 0;
  localparam int EVT_FREQ     = 1;
  localparam int EVT_ANT_TWO  = 2;

  // ****************************************************************
  // demodulator carriers
  // ****************************************************************
  typedef struct packed {
    logic [7:0] level;
    logic       level_valid;
    logic [7:0] ant_one_level;
    logic       ant_one_valid;
    logic [7:0] antenna_two_level;
    logic       ant_two_valid;
    logic [9:0] freq_corr;
    logic       sync_found;
  } rsr_meas_t;

  typedef struct packed {
    logic [7:0]  freq_limit;
    logic [10:0] onoff_count;
    logic        agc_freeze;
    logic        peak_det_en;
    logic        mov_avg_en;
    logic [2:0]  attack;
    logic [3:0]  decay;
  } rsr_ctrl_t;

endpackage

// ===== verilog/rsr_capture.sv
`timescale 1ns/1ps
module rsr_capture
  import rsr_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              arst_n,
  input  wire rsr_pkg::rsr_meas_t meas,
  output logic [7:0]             level_q,
  output logic [7:0]             ant_one_q,
  output logic [7:0]             ant_two_q,
  output logic [9:0]             freq_corr_q
);

  // ****************************************************************
  // measurement latches
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      level_q     <= RST_LEVEL;
      ant_one_q   <= RST_LEVEL;
      ant_two_q   <= RST_LEVEL;
      freq_corr_q <= RST_FREQ_CORR;
    end else begin
      if (meas.level_valid) level_q <= meas.level;
      if (meas.ant_one_valid) ant_one_q <= meas.ant_one_level;
      if (meas.ant_two_valid) ant_two_q <= meas.antenna_two_level;
      // one snapshot per sync word, held until the next one
      if (meas.sync_found) freq_corr_q <= meas.freq_corr;
    end
  end

endmodule // rsr_capture

// ===== verilog/rsr_irq.sv
`timescale 1ns/1ps
module rsr_irq
  import rsr_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  input  wire logic [IRQ_W-1:0] event_in,
  input  wire logic [IRQ_W-1:0] clear_in,
  input  wire logic [IRQ_W-1:0] mask_in,
  output logic [IRQ_W-1:0]      status_q,
  output logic                  irq
);

  // ****************************************************************
  // sticky bits, set wins over clear
  // ****************************************************************
  for (genvar i = 0; i < IRQ_W; i++) begin : g_bit
    always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
        status_q[i] <= RST_IRQ[i];
      end else if (event_in[i]) begin
        status_q[i] <= 1'b1;
      end else if (clear_in[i]) begin
        status_q[i] <= 1'b0;
      end
    end
  end

  assign irq = |(status_q & mask_in);

endmodule // rsr_irq

// ===== verilog/rsr_regs.sv
// The APB register port is this design's own decision.
`timescale 1ns/1ps
// Summary of operation
// - signal level is read-only, latest measurement, zero after reset.
// - clear-channel flag sets while level exceeds threshold, reset 1E.
// - antenna one level register is read-only, measured on first antenna.
// - antenna two level register is read-only, zero after reset.
// - correction limit is read/write, resets 2A, drives the correction loop.
// - ten-bit correction split high/low, latched once per sync word.
// - eleven-bit counter: three high bits plus eight low bits.
// - freeze bit 5 holds the gain control at its current setting.
// - bit 4 enables the peak detector.
// - bit 3 enables the moving-average block.
// - slicer register: attack bits 6:4, decay bits 3:0, bit 7 reserved.
module rsr_regs
  import rsr_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               arst_n,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [PADDR_W-1:0] paddr,
  input  wire logic [PDATA_W-1:0] pwdata,
  input  wire logic [3:0]         pstrb,
  output logic                    pready,
  output logic [PDATA_W-1:0]      prdata,
  output logic                    pslverr,
  input  wire rsr_pkg::rsr_meas_t meas,
  output rsr_pkg::rsr_ctrl_t      ctrl,
  output logic                    clear_channel,
  output logic                    irq
);

  // ****************************************************************
  // byte addresses
  // ****************************************************************
  localparam logic [PADDR_W-1:0] A_LEVEL  = {IDX_SIGNAL_LEVEL, WORD_LSB};
  localparam logic [PADDR_W-1:0] A_THRESH = {IDX_CLEAR_THRESH, WORD_LSB};
  localparam logic [PADDR_W-1:0] A_ANT1   = {IDX_ANT_ONE_LEVEL, WORD_LSB};
  localparam logic [PADDR_W-1:0] A_ANT2   = {IDX_ANT_TWO_LEVEL, WORD_LSB};
  localparam logic [PADDR_W-1:0] A_LIMIT  = {IDX_FREQ_LIMIT, WORD_LSB};
  localparam logic [PADDR_W-1:0] A_CORR   = {IDX_FREQ_CORR_HIGH, WORD_LSB};
  localparam logic [PADDR_W-1:0] A_ONHI   = {IDX_ONOFF_HIGH, WORD_LSB};
  localparam logic [PADDR_W-1:0] A_ONLO   = {IDX_ONOFF_LOW, WORD_LSB};
  localparam logic [PADDR_W-1:0] A_SLICER = {IDX_SLICER_RATES, WORD_LSB};
  localparam logic [PADDR_W-1:0] A_STAT   = {IDX_IRQ_STATUS, WORD_LSB};
  localparam logic [PADDR_W-1:0] A_MASK   = {IDX_IRQ_MASK, WORD_LSB};

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [7:0]       thresh_q;
  logic [7:0]       freq_limit_q;
  logic [5:0]       onoff_high_q;
  logic [7:0]       onoff_low_q;
  logic [7:0]       slicer_q;
  logic [IRQ_W-1:0] mask_q;
  logic [7:0]       level_q;
  logic [7:0]       ant_one_q;
  logic [7:0]       ant_two_q;
  logic [9:0]       freq_corr_q;
  logic [IRQ_W-1:0] status_q;
  logic [IRQ_W-1:0] event_vec;
  logic [IRQ_W-1:0] clear_vec;
  logic [7:0]       rd_byte;
  logic             hit;
  logic [PDATA_W-1:0] prdata_q;
  logic             pslverr_q;

  // ****************************************************************
  // address decode
  // ****************************************************************
  wire setup_ph  = psel & ~penable;
  wire access_ph = psel & penable;
  wire wr_en     = access_ph & pwrite & pstrb[0];
  wire rd_access = access_ph & ~pwrite;
  wire sel_level  = (paddr == A_LEVEL);
  wire sel_thresh = (paddr == A_THRESH);
  wire sel_ant1   = (paddr == A_ANT1);
  wire sel_ant2   = (paddr == A_ANT2);
  wire sel_limit  = (paddr == A_LIMIT);
  wire sel_corr   = (paddr == A_CORR);
  wire sel_onhi   = (paddr == A_ONHI);
  wire sel_onlo   = (paddr == A_ONLO);
  wire sel_slicer = (paddr == A_SLICER);
  wire sel_stat   = (paddr == A_STAT);
  wire sel_mask   = (paddr == A_MASK);
  wire wr_thresh  = wr_en & sel_thresh;
  wire wr_limit   = wr_en & sel_limit;
  wire wr_onhi    = wr_en & sel_onhi;
  wire wr_onlo    = wr_en & sel_onlo;
  wire wr_slicer  = wr_en & sel_slicer;
  wire wr_mask    = wr_en & sel_mask;

  assign hit = sel_level | sel_thresh | sel_ant1 | sel_ant2 | sel_limit |
               sel_corr | sel_onhi | sel_onlo | sel_slicer | sel_stat |
               sel_mask;

  // ****************************************************************
  // writable registers
  // ****************************************************************
  // read-only addresses have no write path at all
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      thresh_q     <= RST_THRESH;
      freq_limit_q <= RST_FREQ_LIMIT;
      onoff_high_q <= RST_ONOFF_HIGH;
      onoff_low_q  <= RST_ONOFF_LOW;
      slicer_q     <= RST_SLICER;
      mask_q       <= RST_IRQ;
    end else begin
      if (wr_thresh) thresh_q <= pwdata[7:0];
      if (wr_limit) freq_limit_q <= pwdata[7:0];
      // bits 7:6 there are correction bits, never written
      if (wr_onhi) onoff_high_q <= pwdata[5:0];
      if (wr_onlo) onoff_low_q <= pwdata[7:0];
      // reserved bit 7 is stored but drives nothing
      if (wr_slicer) slicer_q <= pwdata[7:0];
      if (wr_mask) mask_q <= pwdata[IRQ_W-1:0];
    end
  end

  // ****************************************************************
  // measurement capture
  // ****************************************************************
  rsr_capture u_capture (
    .ref_clk     (ref_clk),
    .arst_n      (arst_n),
    .meas        (meas),
    .level_q     (level_q),
    .ant_one_q   (ant_one_q),
    .ant_two_q   (ant_two_q),
    .freq_corr_q (freq_corr_q)
  );

  // ****************************************************************
  // demodulator controls
  // ****************************************************************
  assign ctrl.freq_limit  = freq_limit_q;
  assign ctrl.onoff_count = {onoff_high_q[2:0], onoff_low_q};
  assign ctrl.agc_freeze  = onoff_high_q[BIT_FREEZE];
  assign ctrl.peak_det_en = onoff_high_q[BIT_PEAK_DET];
  assign ctrl.mov_avg_en  = onoff_high_q[BIT_MOV_AVG];
  assign ctrl.attack      = slicer_q[6:4];
  assign ctrl.decay       = slicer_q[3:0];

  // strictly above, equal does not count
  assign clear_channel = (level_q > thresh_q);

  // ****************************************************************
  // interrupt status
  // ****************************************************************
  assign event_vec[EVT_CLEAR]   = clear_channel;
  assign event_vec[EVT_FREQ]    = meas.sync_found;
  assign event_vec[EVT_ANT_TWO] = meas.ant_two_valid;
  // clear only what the read returned, so nothing set since is lost
  assign clear_vec = (rd_access & sel_stat) ? prdata_q[IRQ_W-1:0] :
                     RST_IRQ;

  rsr_irq u_irq (
    .ref_clk  (ref_clk),
    .arst_n   (arst_n),
    .event_in (event_vec),
    .clear_in (clear_vec),
    .mask_in  (mask_q),
    .status_q (status_q),
    .irq      (irq)
  );

  // ****************************************************************
  // read mux
  // ****************************************************************
  always_comb begin
    if (sel_level) begin
      rd_byte = level_q;
    end else if (sel_thresh) begin
      rd_byte = thresh_q;
    end else if (sel_ant1) begin
      rd_byte = ant_one_q;
    end else if (sel_ant2) begin
      rd_byte = ant_two_q;
    end else if (sel_limit) begin
      rd_byte = freq_limit_q;
    end else if (sel_corr) begin
      rd_byte = freq_corr_q[9:2];
    end else if (sel_onhi) begin
      rd_byte = {freq_corr_q[1:0], onoff_high_q};
    end else if (sel_onlo) begin
      rd_byte = onoff_low_q;
    end else if (sel_slicer) begin
      rd_byte = slicer_q;
    end else if (sel_stat) begin
      rd_byte = {5'h00, status_q};
    end else if (sel_mask) begin
      rd_byte = {5'h00, mask_q};
    end else begin
      rd_byte = 8'h00;
    end
  end

  // ****************************************************************
  // apb answer
  // ****************************************************************
  // data sampled in the setup cycle, so prdata is a flop at access
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata_q  <= '0;
      pslverr_q <= 1'b0;
    end else if (setup_ph) begin
      prdata_q  <= {PAD_ZERO, rd_byte};
      pslverr_q <= ~hit;
    end
  end

  assign pready  = 1'b1;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q & access_ph;

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_level_capture: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    meas.level_valid |=> level_q == $past(meas.level))
    else $error("signal level not captured");

  chk_clear_sets: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (level_q > thresh_q) |=> status_q[EVT_CLEAR])
    else $error("clear-channel flag not set");

  chk_ant_one_hold: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    !meas.ant_one_valid |=> $stable(ant_one_q))
    else $error("antenna one level changed without measurement");

  chk_ant_two_capture: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    meas.ant_two_valid |=> ant_two_q == $past(meas.antenna_two_level))
    else $error("antenna two level not captured");

  chk_limit_write: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    wr_limit |=> ctrl.freq_limit == $past(pwdata[7:0]))
    else $error("correction limit not applied");

  chk_corr_latch: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    meas.sync_found ##1 !meas.sync_found [*2] |->
      freq_corr_q == $past(meas.freq_corr, 2))
    else $error("correction not held since sync word");

  chk_count_low: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    wr_onlo |=> ctrl.onoff_count[7:0] == $past(pwdata[7:0]))
    else $error("counter low bits wrong");

  chk_count_high: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    wr_onhi |=> ctrl.onoff_count[10:8] == $past(pwdata[2:0]))
    else $error("counter high bits wrong");

  chk_freeze_bit: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    wr_onhi |=> ctrl.agc_freeze == $past(pwdata[BIT_FREEZE]))
    else $error("freeze control wrong");

  chk_peak_bit: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    wr_onhi |=> ctrl.peak_det_en == $past(pwdata[BIT_PEAK_DET]))
    else $error("peak detector enable wrong");

  chk_mavg_bit: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    wr_onhi |=> ctrl.mov_avg_en == $past(pwdata[BIT_MOV_AVG]))
    else $error("moving-average enable wrong");

  chk_slicer_fields: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    wr_slicer |=> ctrl.attack == $past(pwdata[6:4]) &&
                  ctrl.decay == $past(pwdata[3:0]))
    else $error("slicer fields wrong");

  chk_ro_ignored: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    wr_en && sel_corr && !meas.sync_found |=> $stable(freq_corr_q))
    else $error("read-only correction was written");

  chk_level_hold: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    !meas.level_valid |=> $stable(level_q))
    else $error("signal level changed without measurement");

  chk_thresh_write: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    wr_thresh |=> thresh_q == $past(pwdata[7:0]))
    else $error("threshold not written");

  chk_status_read: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    rd_access && sel_stat && prdata_q[EVT_CLEAR] && !clear_channel
      |=> !status_q[EVT_CLEAR])
    else $error("clear-channel flag survived its read");

  chk_ant_two_event: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    meas.ant_two_valid |=> status_q[EVT_ANT_TWO])
    else $error("antenna two event not flagged");

  chk_sync_event: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    meas.sync_found |=> status_q[EVT_FREQ])
    else $error("sync word event not flagged");

  chk_corr_high_read: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    setup_ph && sel_corr |=> prdata_q[7:0] == $past(freq_corr_q[9:2]))
    else $error("correction high bits misread");

  chk_corr_low_read: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    setup_ph && sel_onhi |=> prdata_q[7:6] == $past(freq_corr_q[1:0]))
    else $error("correction low bits misread");

  chk_count_readback: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    setup_ph && sel_onhi |=> prdata_q[5:0] == $past(onoff_high_q))
    else $error("counter control bits misread");

  chk_strobe_off: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    access_ph && pwrite && !pstrb[0] |=> $stable(thresh_q) &&
      $stable(freq_limit_q) && $stable(slicer_q))
    else $error("write without low strobe took effect");

  chk_reserved_kept: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    wr_slicer |=> slicer_q[7] == $past(pwdata[7]))
    else $error("reserved slicer bit not stored");

  chk_unmapped_err: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    setup_ph ##1 access_ph |-> pslverr == !hit)
    else $error("error response wrong for address");

endmodule // rsr_regs

// ===== test/rsr_apb_host.sv
`timescale 1ns/1ps
module rsr_apb_host (
  input  wire logic                        ref_clk,
  output logic                             psel,
  output logic                             penable,
  output logic                             pwrite,
  output logic [rsr_pkg::PADDR_W-1:0]      paddr,
  output logic [rsr_pkg::PDATA_W-1:0]      pwdata,
  output logic [3:0]                       pstrb,
  input  wire logic                        pready,
  input  wire logic [rsr_pkg::PDATA_W-1:0] prdata,
  input  wire logic                        pslverr
);
  import rsr_pkg::*;

  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = '0;
    pwdata  = '0;
    pstrb   = 4'h0;
  end

  // ****************************************************************
  // one transfer, entered just after a rising edge
  // ****************************************************************
  task automatic xfer(input logic w, input logic [PADDR_W-1:0] a,
                      input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] r, output logic e);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge ref_clk);
    penable <= 1'b1;
    // no limit of its own: the bench watchdog ends a hung wait
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // released lines must not keep looking valid
    paddr   <= ~a;
    pwdata  <= ~d;
    @(posedge ref_clk);
  endtask
endmodule // rsr_apb_host

// ===== test/test_rx_signal_afc_onoff_regs.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end

module test_rx_signal_afc_onoff_regs;
  import rsr_pkg::*;
  logic               ref_clk, arst_n, psel, penable, pwrite, pready;
  logic               pslverr, clear_channel, irq, er;
  logic [PADDR_W-1:0] paddr;
  logic [31:0]        pwdata, prdata, rd;
  logic [3:0]         pstrb;
  rsr_meas_t          meas, v;
  rsr_ctrl_t          ctrl;
  int                 fail_count, checked, seed;
  logic [7:0]         th, lim, lo, sl, lv, a1, a2;
  logic [5:0]         hi;
  logic [9:0]         corr;

  rsr_apb_host host (.ref_clk(ref_clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr));
  rsr_regs dut (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .meas(meas), .ctrl(ctrl), .clear_channel(clear_channel), .irq(irq));

  initial ref_clk = 1'b0;
  always #5 ref_clk = ~ref_clk;

  // ****************************************************************
  // expectations
  // ****************************************************************
  function automatic rsr_ctrl_t exp_ctrl();
    return {lim, hi[2:0], lo, hi[5], hi[4], hi[3], sl[6:4], sl[3:0]};
  endfunction

  function automatic logic [7:0] exp_reg(input logic [7:0] idx);
    case (idx)
      IDX_SIGNAL_LEVEL:   return lv;
      IDX_CLEAR_THRESH:   return th;
      IDX_ANT_ONE_LEVEL:  return a1;
      IDX_ANT_TWO_LEVEL:  return a2;
      IDX_FREQ_LIMIT:     return lim;
      IDX_FREQ_CORR_HIGH: return corr[9:2];
      IDX_ONOFF_HIGH:     return {corr[1:0], hi};
      IDX_ONOFF_LOW:      return lo;
      IDX_SLICER_RATES:   return sl;
      default:            return 8'h00;
    endcase
  endfunction

  // rate in bit/s; Manchester coding halves the count
  function automatic logic [10:0] onoff_count(input int rate,
                                              input logic manch);
    return 11'((3 * 500000) / (rate * (1 + int'(manch))));
  endfunction

  // ****************************************************************
  // bus and demodulator tasks
  // ****************************************************************
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    host.xfer(1'b1, {idx, WORD_LSB}, {PAD_ZERO, d}, 4'hF, rd, er);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] e);
    host.xfer(1'b0, {idx, WORD_LSB}, 32'h0, 4'hF, rd, er);
    `CHK(rd, {PAD_ZERO, e})
    `CHK(er, 1'b0)
  endtask

  task automatic rd_exp(input logic [7:0] idx);
    rd_chk(idx, exp_reg(idx));
  endtask

  // extra edges let status and irq settle before anyone looks
  task automatic pulse(input rsr_meas_t m);
    meas <= m;
    @(posedge ref_clk);
    meas.level_valid   <= 1'b0;
    meas.ant_one_valid <= 1'b0;
    meas.ant_two_valid <= 1'b0;
    meas.sync_found    <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic set_level(input logic [7:0] l);
    v = meas;
    v.level = l;
    v.level_valid = 1'b1;
    lv = l;
    pulse(v);
  endtask

  task final_report;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #300000;
    fail_count++;
    final_report();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    seed = 32'h8ED5;
    arst_n = 1'b0;
    meas = '0;
    {lv, a1, a2, lo, sl, corr} = '0;
    th = 8'h1E;
    lim = 8'h2A;
    hi = 6'h2C;
    repeat (6) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    `CHK(ctrl, exp_ctrl())
    for (int i = 0; i < 9; i++)
      rd_exp(IDX_SIGNAL_LEVEL + 8'(i));
    rd_chk(IDX_IRQ_STATUS, 8'h00);
    rd_chk(IDX_IRQ_MASK, 8'h00);
    repeat (20) begin
      th = 8'($random(seed));
      lim = 8'($random(seed));
      lo = 8'($random(seed));
      sl = 8'($random(seed));
      hi = 6'($random(seed));
      wr(IDX_CLEAR_THRESH, th);
      wr(IDX_FREQ_LIMIT, lim);
      wr(IDX_ONOFF_LOW, lo);
      wr(IDX_SLICER_RATES, sl);
      wr(IDX_ONOFF_HIGH, {2'($random(seed)), hi});
      `CHK(ctrl, exp_ctrl())
      for (int i = 1; i < 9; i++)
        rd_exp(IDX_SIGNAL_LEVEL + 8'(i));
    end
    // counter for 1 kbps, uncoded and then Manchester coded
    for (int m = 0; m < 2; m++) begin
      {hi, lo} = {3'b000, onoff_count(1000, 1'(m))};
      wr(IDX_ONOFF_HIGH, {2'b00, hi});
      wr(IDX_ONOFF_LOW, lo);
      `CHK(ctrl.onoff_count, onoff_count(1000, 1'(m)))
      `CHK(ctrl, exp_ctrl())
    end
    for (int i = 0; i < 4; i++) begin
      v.level = (i == 0) ? IDX_SIGNAL_LEVEL : (i == 1) ? IDX_ANT_ONE_LEVEL :
                (i == 2) ? IDX_ANT_TWO_LEVEL : IDX_FREQ_CORR_HIGH;
      wr(v.level, ~exp_reg(v.level));
      rd_chk(v.level, exp_reg(v.level));
    end
    host.xfer(1'b1, {IDX_CLEAR_THRESH, WORD_LSB}, {PAD_ZERO, ~th}, 4'hE,
              rd, er);
    rd_chk(IDX_CLEAR_THRESH, th);
    host.xfer(1'b0, 10'h3FC, 32'h0, 4'hF, rd, er);
    `CHK({er, rd}, {1'b1, 32'h0})
    host.xfer(1'b0, 10'h09D, 32'h0, 4'hF, rd, er);
    `CHK(er, 1'b1)
    wr(IDX_IRQ_MASK, 8'h01);
    for (int i = 0; i < 24; i++) begin
      set_level(8'h00);
      host.xfer(1'b0, {IDX_IRQ_STATUS, WORD_LSB}, 32'h0, 4'hF, rd, er);
      th = (i < 2) ? 8'h80 : 8'($random(seed));
      wr(IDX_CLEAR_THRESH, th);
      set_level((i < 2) ? 8'h80 + 8'(i) : 8'($random(seed)));
      `CHK(clear_channel, lv > th)
      `CHK(irq, lv > th)
      rd_chk(IDX_SIGNAL_LEVEL, lv);
      rd_chk(IDX_IRQ_STATUS, {7'h00, lv > th});
    end
    wr(IDX_CLEAR_THRESH, 8'h10);
    th = 8'h10;
    set_level(8'hFF);
    `CHK(irq, 1'b1)
    wr(IDX_IRQ_MASK, 8'h06);
    `CHK(irq, 1'b0)
    a1 = 8'($random(seed));
    a2 = 8'($random(seed));
    corr = 10'($random(seed));
    v = meas;
    {v.ant_one_level, v.antenna_two_level, v.freq_corr} = {a1, a2, corr};
    {v.ant_one_valid, v.ant_two_valid, v.sync_found} = 3'h7;
    pulse(v);
    `CHK(irq, 1'b1)
    rd_chk(IDX_IRQ_STATUS, 8'h07);
    `CHK(irq, 1'b0)
    // a new correction without a sync word must not be taken
    v.freq_corr = ~corr;
    {v.ant_one_valid, v.ant_two_valid, v.sync_found} = 3'h0;
    pulse(v);
    for (int i = 2; i < 7; i++)
      rd_exp(IDX_SIGNAL_LEVEL + 8'(i));
    final_report();
  end
endmodule // test_rx_signal_afc_onoff_regs
